// File: bctf_pkg.sv
// Package: constants, state encodings and carrier types for the bus-cycle trigger block
// Summary of operation
// - Drive out a local copy of bus clock.
// - State is {aclken, dclken, trigger, aux} encoded.
// - All state updates on rising clock edge.
// - Motherboard reset forces idle every clock edge.
// - Start on CPU request, or I/O when PCI-clock low.
// - CPU cycle leaves start on last word and done.
// - I/O cycle leaves start on slave done alone.
// - Address hold, data hold, fire first, fire second.
// - Fire second exits on request gone or dropped.
// - Dropped flag: set on request gone, cleared idle.
// - Active-low enables sample capture registers, else hold.
// - Trigger fires for CPU and PCI memory cycles.
// - Active-low CPU interrupt reports hardware trigger condition.
// - PCI-side clock only qualifies I/O-master starts.
package bctf_pkg;

  // ----------------------------------------------------------------
  // State encodings {addr enable, data enable, trigger, aux}
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE        = 4'h0,
    ST_BEGIN       = 4'hC,
    ST_ADDR_HOLD   = 4'h4,
    ST_DATA_HOLD   = 4'h1,
    ST_FIRE_FIRST  = 4'h2,
    ST_FIRE_SECOND = 4'h3
  } bctf_state_t;

  localparam int unsigned ST_BIT_ACLKEN    = 3;
  localparam int unsigned ST_BIT_DCLKEN    = 2;
  localparam int unsigned ST_BIT_TRIG      = 1;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0]  REG_CTRL      = 8'h00;
  localparam logic [7:0]  REG_STATUS    = 8'h04;
  localparam logic [7:0]  REG_IRQ_STAT  = 8'h08;
  localparam logic [7:0]  REG_IRQ_MASK  = 8'h0C;
  localparam logic [7:0]  REG_CAP_ADDR  = 8'h10;
  localparam logic [7:0]  REG_CAP_DLO   = 8'h14;
  localparam logic [7:0]  REG_CAP_DHI   = 8'h18;
  localparam logic [7:0]  REG_TRIG_CNT  = 8'h1C;
  localparam int unsigned ADDR_W        = 8;

  typedef enum logic [3:0] {
    SEL_CTRL, SEL_STATUS, SEL_IRQ_STAT, SEL_IRQ_MASK,
    SEL_CAP_ADDR, SEL_CAP_DLO, SEL_CAP_DHI, SEL_TRIG_CNT, SEL_NONE
  } bctf_sel_t;

  // Control fields
  localparam int unsigned CTRL_RUN_BIT  = 0;
  localparam int unsigned CTRL_SWI_BIT  = 1;
  localparam logic [1:0]  CTRL_RESET    = 2'h1;

  // Interrupt status fields
  localparam int unsigned IRQ_W         = 3;
  localparam int unsigned IRQ_FIRE_BIT  = 0;
  localparam int unsigned IRQ_EXT_BIT   = 1;
  localparam int unsigned IRQ_DROP_BIT  = 2;
  localparam logic [2:0]  IRQ_MASK_RST  = 3'h0;

  // Status register fields
  localparam int unsigned STAT_DROP_BIT = 4;
  localparam int unsigned STAT_RD_BIT   = 5;
  localparam int unsigned STAT_BLK_BIT  = 6;
  localparam int unsigned STAT_IOM_BIT  = 7;

  localparam int unsigned CNT_W         = 16;

  // ----------------------------------------------------------------
  // Carrier for the synchronised bus status pins (all active high)
  // ----------------------------------------------------------------
  typedef struct packed {
    logic rq;
    logic last;
    logic done;
    logic iom;
    logic pclk;
    logic rst;
    logic xtrig;
    logic rd;
    logic blk;
  } bctf_bus_t;

  localparam int unsigned BUS_W = 9;

endpackage : bctf_pkg

// File: bctf_sync.sv
// Two-flop synchroniser for a vector of pin levels
`timescale 1ns/100ps
`default_nettype none
module bctf_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rstn_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] q_ff;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta_ff <= '0;
      q_ff    <= '0;
    end else begin
      meta_ff <= d_i;
      q_ff    <= meta_ff;
    end
  end

  assign q_o = q_ff;

endmodule : bctf_sync
`default_nettype wire

// File: bctf_cap_reg.sv
// Capture register with active-low sample enable
`timescale 1ns/100ps
`default_nettype none
module bctf_cap_reg #(
  parameter int unsigned W = 32
) (
  input  wire logic         clk_i,
  input  wire logic         rstn_i,
  input  wire logic         en_n_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] q_ff;
  logic [W-1:0] nxt_q;

  always_comb begin
    nxt_q = en_n_i ? q_ff : d_i;
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      q_ff <= '0;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign q_o = q_ff;

endmodule : bctf_cap_reg
`default_nettype wire

// File: bctf_top.sv
// Bus-cycle trigger state machine with capture registers and APB slave
`timescale 1ns/100ps
`default_nettype none
module bctf_top #(
  parameter int unsigned AW = 32,
  parameter int unsigned DW = 64
) (
  input  wire logic                 clk_i,
  input  wire logic                 rstn_i,
  // Bus status pins, active low as on the board, except the PCI-side clock, reset and trigger
  input  wire logic                 mreq_n_i,
  input  wire logic                 mlast_n_i,
  input  wire logic                 slv_done_n_i,
  input  wire logic                 iom_gnt_n_i,
  input  wire logic                 rd_n_i,
  input  wire logic                 block_n_i,
  input  wire logic                 pci_side_clock_i,
  input  wire logic                 dbg_rst_i,
  input  wire logic                 ext_trig_i,
  input  wire logic [AW-1:0]        bus_addr_i,
  input  wire logic [DW-1:0]        bus_data_i,
  // Outputs to analyser and CPU
  output logic                      addr_clk_o,
  output logic                      aclken_n_o,
  output logic                      dclken_n_o,
  output logic                      atrig_o,
  output logic                      dbgint_n_o,
  output logic                      irq_o,
  output logic [AW-1:0]             cap_addr_o,
  output logic [DW-1:0]             cap_data_o,
  // APB slave
  input  wire logic                 psel_i,
  input  wire logic                 penable_i,
  input  wire logic                 pwrite_i,
  input  wire logic [bctf_pkg::ADDR_W-1:0] paddr_i,
  input  wire logic [31:0]          pwdata_i,
  output logic [31:0]               prdata_o,
  output logic                      pready_o,
  output logic                      pslverr_o
);

  // ----------------------------------------------------------------
  // Register address decode
  // ----------------------------------------------------------------
  function automatic bctf_pkg::bctf_sel_t reg_sel(input logic [bctf_pkg::ADDR_W-1:0] a);
    case (a)
      bctf_pkg::REG_CTRL:     reg_sel = bctf_pkg::SEL_CTRL;
      bctf_pkg::REG_STATUS:   reg_sel = bctf_pkg::SEL_STATUS;
      bctf_pkg::REG_IRQ_STAT: reg_sel = bctf_pkg::SEL_IRQ_STAT;
      bctf_pkg::REG_IRQ_MASK: reg_sel = bctf_pkg::SEL_IRQ_MASK;
      bctf_pkg::REG_CAP_ADDR: reg_sel = bctf_pkg::SEL_CAP_ADDR;
      bctf_pkg::REG_CAP_DLO:  reg_sel = bctf_pkg::SEL_CAP_DLO;
      bctf_pkg::REG_CAP_DHI:  reg_sel = bctf_pkg::SEL_CAP_DHI;
      bctf_pkg::REG_TRIG_CNT: reg_sel = bctf_pkg::SEL_TRIG_CNT;
      default:                reg_sel = bctf_pkg::SEL_NONE;
    endcase
  endfunction : reg_sel

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  bctf_pkg::bctf_bus_t bus_raw;
  bctf_pkg::bctf_bus_t bus;
  logic [AW-1:0]       addr_q;
  logic [DW-1:0]       data_q;

  assign bus_raw = '{rq: ~mreq_n_i, last: ~mlast_n_i, done: ~slv_done_n_i, iom: ~iom_gnt_n_i,
                     pclk: pci_side_clock_i, rst: dbg_rst_i, xtrig: ext_trig_i,
                     rd: ~rd_n_i, blk: ~block_n_i};

  bctf_sync #(.W(bctf_pkg::BUS_W)) u_sync_ctl (
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .d_i    (bus_raw),
    .q_o    (bus)
  );

  bctf_sync #(.W(AW + DW)) u_sync_dat (
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .d_i    ({bus_addr_i, bus_data_i}),
    .q_o    ({addr_q, data_q})
  );

  // Capture registers sample the bus lines two clocks late, through the synchroniser; the local clock copy is the bus clock itself
  assign addr_clk_o = clk_i;

  // ----------------------------------------------------------------
  // Trigger state machine
  // ----------------------------------------------------------------
  bctf_pkg::bctf_state_t state_ff;
  bctf_pkg::bctf_state_t nxt_state;
  logic                  drop_ff;
  logic                  nxt_drop;
  logic                  run_ff;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      bctf_pkg::ST_IDLE: begin
        // Half-rate clock only gates I/O-master starts
        if (run_ff && bus.rq && (!bus.iom || !bus.pclk)) begin
          nxt_state = bctf_pkg::ST_BEGIN;
        end
      end
      bctf_pkg::ST_BEGIN: begin
        if (!bus.iom && bus.last && bus.done) begin
          nxt_state = bctf_pkg::ST_ADDR_HOLD;
        end else if (bus.iom && bus.done) begin
          nxt_state = bctf_pkg::ST_ADDR_HOLD;
        end
      end
      bctf_pkg::ST_ADDR_HOLD:  nxt_state = bctf_pkg::ST_DATA_HOLD;
      bctf_pkg::ST_DATA_HOLD:  nxt_state = bctf_pkg::ST_FIRE_FIRST;
      bctf_pkg::ST_FIRE_FIRST: nxt_state = bctf_pkg::ST_FIRE_SECOND;
      bctf_pkg::ST_FIRE_SECOND: begin
        if (!bus.rq || drop_ff) begin
          nxt_state = bctf_pkg::ST_IDLE;
        end
      end
      default: nxt_state = bctf_pkg::ST_IDLE;
    endcase
    if (bus.rst) begin
      nxt_state = bctf_pkg::ST_IDLE;
    end
  end

  always_comb begin
    nxt_drop = (state_ff != bctf_pkg::ST_IDLE) && (!bus.rq || drop_ff);
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_ff <= bctf_pkg::ST_IDLE;
      drop_ff  <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      drop_ff  <= nxt_drop;
    end
  end

  // State bits drive the pins directly, so the outputs are glitch-free
  assign aclken_n_o = ~state_ff[bctf_pkg::ST_BIT_ACLKEN];
  assign dclken_n_o = ~state_ff[bctf_pkg::ST_BIT_DCLKEN];
  assign atrig_o    = state_ff[bctf_pkg::ST_BIT_TRIG];

  bctf_cap_reg #(.W(AW)) u_cap_addr (
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .en_n_i (aclken_n_o),
    .d_i    (addr_q),
    .q_o    (cap_addr_o)
  );

  bctf_cap_reg #(.W(DW)) u_cap_data (
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .en_n_i (dclken_n_o),
    .d_i    (data_q),
    .q_o    (cap_data_o)
  );

  // ----------------------------------------------------------------
  // Events, interrupt status and mask
  // ----------------------------------------------------------------
  logic                          xtrig_d_ff;
  logic [bctf_pkg::IRQ_W-1:0]    irq_stat_ff;
  logic [bctf_pkg::IRQ_W-1:0]    nxt_irq_stat;
  logic [bctf_pkg::IRQ_W-1:0]    irq_mask_ff;
  logic [bctf_pkg::IRQ_W-1:0]    nxt_irq_mask;
  logic [bctf_pkg::IRQ_W-1:0]    ev;
  logic [1:0]                    ctrl_ff;
  logic [1:0]                    nxt_ctrl;
  logic [bctf_pkg::CNT_W-1:0]    cnt_ff;
  logic [bctf_pkg::CNT_W-1:0]    nxt_cnt;
  logic                          wr_acc;
  bctf_pkg::bctf_sel_t           sel;

  assign sel    = reg_sel(paddr_i);
  assign wr_acc = psel_i && penable_i && pwrite_i;
  assign run_ff = ctrl_ff[bctf_pkg::CTRL_RUN_BIT];

  always_comb begin
    ev = '0;
    ev[bctf_pkg::IRQ_FIRE_BIT] = (state_ff == bctf_pkg::ST_DATA_HOLD) && !bus.rst;
    ev[bctf_pkg::IRQ_EXT_BIT]  = bus.xtrig && !xtrig_d_ff;
    ev[bctf_pkg::IRQ_DROP_BIT] = nxt_drop && !drop_ff;
    nxt_irq_stat = irq_stat_ff;
    nxt_irq_mask = irq_mask_ff;
    nxt_ctrl     = ctrl_ff;
    nxt_cnt      = cnt_ff + bctf_pkg::CNT_W'(ev[bctf_pkg::IRQ_FIRE_BIT]);
    if (wr_acc && sel == bctf_pkg::SEL_IRQ_STAT) begin
      nxt_irq_stat = irq_stat_ff & ~pwdata_i[bctf_pkg::IRQ_W-1:0];
    end
    if (wr_acc && sel == bctf_pkg::SEL_IRQ_MASK) begin
      nxt_irq_mask = pwdata_i[bctf_pkg::IRQ_W-1:0];
    end
    if (wr_acc && sel == bctf_pkg::SEL_CTRL) begin
      nxt_ctrl = pwdata_i[1:0];
    end
    if (wr_acc && sel == bctf_pkg::SEL_TRIG_CNT) begin
      nxt_cnt = '0;
    end
    // A new event in the clearing cycle is kept
    nxt_irq_stat = nxt_irq_stat | ev;
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      xtrig_d_ff  <= 1'b0;
      irq_stat_ff <= '0;
      irq_mask_ff <= bctf_pkg::IRQ_MASK_RST;
      ctrl_ff     <= bctf_pkg::CTRL_RESET;
      cnt_ff      <= '0;
    end else begin
      xtrig_d_ff  <= bus.xtrig;
      irq_stat_ff <= nxt_irq_stat;
      irq_mask_ff <= nxt_irq_mask;
      ctrl_ff     <= nxt_ctrl;
      cnt_ff      <= nxt_cnt;
    end
  end

  // Software can raise the CPU interrupt too, to test the handler
  assign irq_o      = |(irq_stat_ff & irq_mask_ff);
  assign dbgint_n_o = ~(irq_o || ctrl_ff[bctf_pkg::CTRL_SWI_BIT]);

  // ----------------------------------------------------------------
  // APB read path: zero wait states, registered read data
  // ----------------------------------------------------------------
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic [31:0] stat_word;

  always_comb begin
    stat_word = '0;
    stat_word[3:0]                     = state_ff;
    stat_word[bctf_pkg::STAT_DROP_BIT] = drop_ff;
    stat_word[bctf_pkg::STAT_RD_BIT]   = bus.rd;
    stat_word[bctf_pkg::STAT_BLK_BIT]  = bus.blk;
    stat_word[bctf_pkg::STAT_IOM_BIT]  = bus.iom;
    nxt_rdata = rdata_ff;
    if (psel_i && !penable_i && !pwrite_i) begin
      case (sel)
        bctf_pkg::SEL_CTRL:     nxt_rdata = {30'h0, ctrl_ff};
        bctf_pkg::SEL_STATUS:   nxt_rdata = stat_word;
        bctf_pkg::SEL_IRQ_STAT: nxt_rdata = {29'h0, irq_stat_ff};
        bctf_pkg::SEL_IRQ_MASK: nxt_rdata = {29'h0, irq_mask_ff};
        bctf_pkg::SEL_CAP_ADDR: nxt_rdata = cap_addr_o[31:0];
        bctf_pkg::SEL_CAP_DLO:  nxt_rdata = cap_data_o[31:0];
        bctf_pkg::SEL_CAP_DHI:  nxt_rdata = cap_data_o[63:32];
        bctf_pkg::SEL_TRIG_CNT: nxt_rdata = {16'h0, cnt_ff};
        default:                nxt_rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_ff <= '0;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign prdata_o  = rdata_ff;
  assign pready_o  = 1'b1;
  assign pslverr_o = psel_i && penable_i && (sel == bctf_pkg::SEL_NONE);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  a_reset_to_idle: assert property (bus.rst |=> state_ff == bctf_pkg::ST_IDLE)
    else $error("motherboard reset did not force idle");

  a_cpu_start: assert property (state_ff == bctf_pkg::ST_IDLE && run_ff && bus.rq && !bus.iom && !bus.rst
                                |=> state_ff == bctf_pkg::ST_BEGIN)
    else $error("cpu request did not start");

  a_iom_qualify: assert property (state_ff == bctf_pkg::ST_IDLE && bus.iom && bus.pclk
                                  |=> state_ff == bctf_pkg::ST_IDLE)
    else $error("io master start while pci clock high");

  a_cpu_wait_last: assert property (state_ff == bctf_pkg::ST_BEGIN && !bus.iom && !bus.last && !bus.rst
                                    |=> state_ff == bctf_pkg::ST_BEGIN)
    else $error("cpu cycle left start without last word");

  a_iom_done_exit: assert property (state_ff == bctf_pkg::ST_BEGIN && bus.iom && bus.done && !bus.rst
                                    |=> state_ff == bctf_pkg::ST_ADDR_HOLD)
    else $error("io master cycle did not leave start on done");

  a_step_chain: assert property (state_ff == bctf_pkg::ST_ADDR_HOLD && !bus.rst ##1 !bus.rst ##1 !bus.rst
                                 |=> state_ff == bctf_pkg::ST_FIRE_SECOND)
    else $error("hold and fire sequence broken");

  a_fire_exit: assert property (state_ff == bctf_pkg::ST_FIRE_SECOND && bus.rq && !drop_ff && !bus.rst
                                |=> state_ff == bctf_pkg::ST_FIRE_SECOND)
    else $error("fire second left while request held");

  a_drop_flag: assert property (state_ff != bctf_pkg::ST_IDLE && !bus.rq
                                |=> drop_ff ##1 (drop_ff || $past(state_ff) == bctf_pkg::ST_IDLE))
    else $error("dropped flag not set and held");

  a_drop_clear: assert property (state_ff == bctf_pkg::ST_IDLE |=> !drop_ff)
    else $error("dropped flag not cleared in idle");

  a_addr_sample: assert property (!aclken_n_o |=> cap_addr_o == $past(addr_q))
    else $error("address capture did not sample");

  a_data_hold: assert property (dclken_n_o |=> $stable(cap_data_o))
    else $error("data capture changed while disabled");

  // A motherboard reset in the first fire state legally cuts the pulse short
  a_trig_two: assert property ($rose(atrig_o) && !bus.rst |-> atrig_o [*2])
    else $error("trigger shorter than two cycles");

  a_irq_level: assert property (irq_stat_ff[bctf_pkg::IRQ_FIRE_BIT] && irq_mask_ff[bctf_pkg::IRQ_FIRE_BIT]
                                |-> !dbgint_n_o)
    else $error("interrupt output not asserted");

  c_cpu_cycle: cover property (state_ff == bctf_pkg::ST_BEGIN && !bus.iom ##1 state_ff == bctf_pkg::ST_ADDR_HOLD);
  c_iom_cycle: cover property (state_ff == bctf_pkg::ST_BEGIN && bus.iom ##1 state_ff == bctf_pkg::ST_ADDR_HOLD);
  c_drop_exit: cover property (state_ff == bctf_pkg::ST_FIRE_SECOND && bus.rq && drop_ff);
  c_irq_clear: cover property (wr_acc && sel == bctf_pkg::SEL_IRQ_STAT && irq_o);

endmodule : bctf_top
`default_nettype wire

// File: bctf_bus_model.sv
// Host-side bus master model driving the cycle status pins and bus lines
`timescale 1ns/100ps
`default_nettype none
module bctf_bus_model (
  input  wire logic        clk_i,
  input  wire logic        pclk_run_i,
  output logic             mreq_n_o,
  output logic             mlast_n_o,
  output logic             slv_done_n_o,
  output logic             iom_gnt_n_o,
  output logic             rd_n_o,
  output logic             block_n_o,
  output logic             pci_side_clock_o,
  output logic [31:0]      bus_addr_o,
  output logic [63:0]      bus_data_o
);
  initial begin
    {mreq_n_o, mlast_n_o, slv_done_n_o, iom_gnt_n_o, rd_n_o, block_n_o} = 6'h3F;
    pci_side_clock_o = 1'b0;
    bus_addr_o       = 32'h0;
    bus_data_o       = 64'h0;
  end

  // Parking the half-rate clock high is how a scenario holds off I/O-master starts
  always @(posedge clk_i) begin
    pci_side_clock_o <= pclk_run_i ? ~pci_side_clock_o : 1'b1;
  end

  // ----------------------------------------------------------------
  // One bus cycle of words data items; drop releases the request once in each word
  // ----------------------------------------------------------------
  task automatic xfer(input logic iom, input logic rd, input logic [31:0] a, input logic [63:0] d,
                      input int words, input logic drop);
    int i;
    @(posedge clk_i);
    mreq_n_o    <= 1'b0;
    iom_gnt_n_o <= ~iom;
    rd_n_o      <= ~rd;
    block_n_o   <= (words == 1);
    bus_addr_o  <= a;
    for (i = 0; i < words; i++) begin
      bus_data_o <= d ^ 64'(i);
      repeat (4) @(posedge clk_i);
      if (drop) begin
        mreq_n_o <= 1'b1;
        @(posedge clk_i);
        mreq_n_o <= 1'b0;
        repeat (2) @(posedge clk_i);
      end
      mlast_n_o    <= (i != words - 1);
      slv_done_n_o <= 1'b0;
      @(posedge clk_i);
      mlast_n_o    <= 1'b1;
      slv_done_n_o <= 1'b0 ^ 1'b1;
    end
    repeat (8) @(posedge clk_i);
    // Released address and data lines show the inverse of their last value, never a stale copy
    mreq_n_o    <= 1'b1;
    iom_gnt_n_o <= 1'b1;
    rd_n_o      <= 1'b1;
    block_n_o   <= 1'b1;
    bus_addr_o  <= ~a;
    bus_data_o  <= ~(d ^ 64'(words - 1));
    repeat (4) @(posedge clk_i);
  endtask : xfer
endmodule : bctf_bus_model
`default_nettype wire

// File: test_bus_cycle_trigger_fsm.sv
// Self-checking testbench for the bus-cycle trigger block
`timescale 1ns/100ps
`default_nettype none
module test_bus_cycle_trigger_fsm;
  typedef struct packed {
    logic [31:0] a;
    logic [63:0] d;
    logic        drop;
  } bctf_exp_t;

  logic        clk_i, rstn_i, dbg_rst_i, ext_trig_i, pclk_run;
  logic        psel_i, penable_i, pwrite_i, pready_o, pslverr_o, err;
  logic [7:0]  paddr_i;
  logic [31:0] pwdata_i, prdata_o, rdat, baddr, cap_addr_o;
  logic [63:0] bdata, cap_data_o;
  logic        mreq_n, mlast_n, done_n, iom_n, rd_n, blk_n, pclk;
  logic        addr_clk_o, aclken_n_o, dclken_n_o, atrig_o, dbgint_n_o, irq_o;
  int          fails = 0;
  int          compares = 0;
  int          cyc = 0;
  int          seed = 82;
  bctf_exp_t   expq[$];

  bctf_top u_dut (.clk_i(clk_i), .rstn_i(rstn_i), .mreq_n_i(mreq_n), .mlast_n_i(mlast_n),
    .slv_done_n_i(done_n), .iom_gnt_n_i(iom_n), .rd_n_i(rd_n), .block_n_i(blk_n),
    .pci_side_clock_i(pclk), .dbg_rst_i(dbg_rst_i), .ext_trig_i(ext_trig_i), .bus_addr_i(baddr),
    .bus_data_i(bdata), .addr_clk_o(addr_clk_o), .aclken_n_o(aclken_n_o), .dclken_n_o(dclken_n_o),
    .atrig_o(atrig_o), .dbgint_n_o(dbgint_n_o), .irq_o(irq_o), .cap_addr_o(cap_addr_o),
    .cap_data_o(cap_data_o), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o));

  bctf_bus_model u_bus (.clk_i(clk_i), .pclk_run_i(pclk_run), .mreq_n_o(mreq_n), .mlast_n_o(mlast_n),
    .slv_done_n_o(done_n), .iom_gnt_n_o(iom_n), .rd_n_o(rd_n), .block_n_o(blk_n),
    .pci_side_clock_o(pclk), .bus_addr_o(baddr), .bus_data_o(bdata));

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic test_done();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : test_done

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk_i);
    psel_i    <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i  <= wr;
    paddr_i   <= a;
    pwdata_i  <= wd;
    @(posedge clk_i);
    penable_i <= 1'b1;
    // The wait ends when pready_o is high; the bench timeout ends it otherwise
    do begin
      @(posedge clk_i);
    end while (pready_o !== 1'b1);
    rdat = prdata_o;
    err  = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb

  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(nm, 64'(rdat & m), 64'(e));
  endtask : rd_chk

  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fails++;
      test_done();
    end
  end

  // ----------------------------------------------------------------
  // Monitor: each trigger pulse takes the oldest expected capture
  // ----------------------------------------------------------------
  initial begin : mon
    bctf_exp_t e;
    int        hi;
    logic      was;
    was = 1'b0;
    hi  = 0;
    e   = '0;
    forever begin
      @(posedge clk_i);
      if (atrig_o === 1'b1 && !was) begin
        if (expq.size() == 0) begin
          check("spurious trigger", 64'h1, 64'h0);
        end else begin
          e = expq.pop_front();
          check("cap addr", 64'(cap_addr_o), 64'(e.a));
          check("cap data", cap_data_o, e.d);
        end
        hi = 0;
      end
      if (atrig_o === 1'b1) begin
        hi++;
      end else if (was) begin
        check("trigger two cycles", 64'(hi == 2), 64'(e.drop));
      end
      was = (atrig_o === 1'b1);
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin : main
    logic [31:0] a;
    logic [63:0] d;
    int          k;
    {rstn_i, dbg_rst_i, ext_trig_i, psel_i, penable_i, pwrite_i} = 6'h0;
    pclk_run = 1'b1;
    paddr_i  = 8'h00;
    pwdata_i = 32'h0;
    repeat (6) @(posedge clk_i);
    rstn_i <= 1'b1;
    rd_chk("ctrl reset", bctf_pkg::REG_CTRL, 32'h3, 32'h1);
    rd_chk("mask reset", bctf_pkg::REG_IRQ_MASK, 32'h7, 32'h0);
    rd_chk("state idle", bctf_pkg::REG_STATUS, 32'hF, 32'h0);
    check("dbgint idle", 64'(dbgint_n_o), 64'h1);
    apb(1'b0, 8'h20, 32'h0);
    check("unmapped err", 64'(err), 64'h1);
    check("unmapped data", 64'(rdat), 64'h0);
    @(negedge clk_i);
    #2 check("addr clk low", 64'(addr_clk_o), 64'h0);
    @(posedge clk_i);
    #2 check("addr clk high", 64'(addr_clk_o), 64'h1);
    apb(1'b1, bctf_pkg::REG_IRQ_MASK, 32'h7);
    // CPU write, I/O write, CPU block read of three words, I/O read
    for (k = 0; k < 4; k++) begin
      a = $random(seed);
      d = {$random(seed), $random(seed)};
      expq.push_back('{a, d ^ 64'((k == 2) ? 2 : 0), 1'b0});
      u_bus.xfer(k[0], k[1], a, d, (k == 2) ? 3 : 1, 1'b0);
    end
    repeat (4) @(posedge clk_i);
    check("irq fire", 64'(irq_o), 64'h1);
    check("dbgint fire", 64'(dbgint_n_o), 64'h0);
    rd_chk("fire flag", bctf_pkg::REG_IRQ_STAT, 32'h5, 32'h5);
    rd_chk("trig count", bctf_pkg::REG_TRIG_CNT, 32'hFFFF, 32'h4);
    apb(1'b1, bctf_pkg::REG_IRQ_STAT, 32'h7);
    apb(1'b1, bctf_pkg::REG_IRQ_MASK, 32'h1);
    ext_trig_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    ext_trig_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    check("irq masked", 64'(irq_o), 64'h0);
    rd_chk("ext flag", bctf_pkg::REG_IRQ_STAT, 32'h7, 32'h2);
    apb(1'b1, bctf_pkg::REG_IRQ_MASK, 32'h2);
    repeat (2) @(posedge clk_i);
    check("irq unmasked", 64'(irq_o), 64'h1);
    apb(1'b1, bctf_pkg::REG_IRQ_STAT, 32'h2);
    repeat (2) @(posedge clk_i);
    check("irq cleared", 64'(irq_o), 64'h0);
    check("dbgint cleared", 64'(dbgint_n_o), 64'h1);
    // Run off, software interrupt on: a CPU cycle must not start
    apb(1'b1, bctf_pkg::REG_CTRL, 32'h2);
    repeat (2) @(posedge clk_i);
    check("dbgint soft", 64'(dbgint_n_o), 64'h0);
    u_bus.xfer(1'b0, 1'b0, 32'h0000_2000, 64'h0, 1, 1'b0);
    apb(1'b1, bctf_pkg::REG_CTRL, 32'h1);
    pclk_run <= 1'b0;
    repeat (3) @(posedge clk_i);
    u_bus.xfer(1'b1, 1'b0, 32'h0000_1000, 64'h0, 1, 1'b0);
    pclk_run <= 1'b1;
    rd_chk("io refused", bctf_pkg::REG_TRIG_CNT, 32'hFFFF, 32'h4);
    a = $random(seed);
    d = {$random(seed), $random(seed)};
    expq.push_back('{a, d, 1'b1});
    u_bus.xfer(1'b0, 1'b1, a, d, 1, 1'b1);
    // Early exit restarts on the still-held request, then the request drops
    check("restart begin", 64'(aclken_n_o), 64'h0);
    rd_chk("dropped begin", bctf_pkg::REG_STATUS, 32'h1F, 32'h1C);
    dbg_rst_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    check("reset addr en", 64'(aclken_n_o), 64'h1);
    check("reset data en", 64'(dclken_n_o), 64'h1);
    dbg_rst_i <= 1'b0;
    rd_chk("idle after reset", bctf_pkg::REG_STATUS, 32'h1F, 32'h0);
    repeat (4) @(posedge clk_i);
    check("queue empty", 64'(expq.size()), 64'h0);
    test_done();
  end
endmodule : test_bus_cycle_trigger_fsm
`default_nettype wire
